// ---- design/sar_adc_map.svh ----
// Constants for the converter control block: timing, codes, register map.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef SAR_ADC_MAP_SVH
`define SAR_ADC_MAP_SVH

`define CLK_PERIOD_NS 5
`define CONV_TIME_NS 200
`define CONV_CYC ((`CONV_TIME_NS) / (`CLK_PERIOD_NS))
`define ABORT_TIME_NS 45
`define ABORT_CYC ((`ABORT_TIME_NS) / (`CLK_PERIOD_NS))
`define RESET_PHASE_CYC_DEF 20
`define POWERDOWN_CYC_DEF 400

`define ABORT_CODE 12'hFE0
`define INIT_CONVS 3'h4
`define LEN_W 8

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RESULT 8'h08
`define REG_COUNT 8'h0C

`define STAT_BUSY 0
`define STAT_SAMPLING 1
`define STAT_NAP 2
`define STAT_RESET 3
`define STAT_PWRDN 4
`define STAT_ABORTED 5
`define STAT_VALID 6
`define STAT_INIT_LSB 8

`endif

// ---- design/sar_adc_pkg.sv ----
// Types shared by the converter control block.
// Assumes sar_adc_map.svh is on the include path.
`default_nettype none
`include "sar_adc_map.svh"

package sar_adc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_TAIL} conv_state_e;

    typedef struct packed {
        conv_state_e state;
        logic sampling;
        logic nap;
        logic cs_prev;
        logic cst_prev;
        logic pwd_meta;
        logic pwd_sync;
        logic [15:0] pwd_cnt;
        logic reset_phase;
        logic powerdown;
        logic [11:0] result;
        logic aborted;
        logic [2:0] init_cnt;
        logic [11:0] bus_data;
        logic [`LEN_W-1:0] conv_len;
        logic [15:0] conv_total;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] hrdata;
    } ctl_state_s;
endpackage

`default_nettype wire

// ---- design/sar_conv_timer.sv ----
// Conversion timer: counts the internal conversion clock after a start.
// Assumes a synchronous active-high reset and a length of at least one.
`default_nettype none

module sar_conv_timer #(
    parameter int LEN_W = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_start,
    input wire logic i_stop,
    input wire logic [LEN_W-1:0] i_length,
    output logic o_running,
    output logic o_done
);
    typedef struct packed {
        logic running;
        logic [LEN_W-1:0] cnt;
    } timer_state_s;

    timer_state_s st_reg;
    timer_state_s st_next;

    assign o_running = st_reg.running;
    assign o_done = st_reg.running && (st_reg.cnt >= i_length);

    always_comb begin
        st_next = st_reg;
        if (i_stop) begin
            st_next.running = 1'b0;
        end else if (i_start) begin
            st_next.running = 1'b1;
            st_next.cnt = LEN_W'(1);
        end else if (o_done) begin
            st_next.running = 1'b0;
        end else if (st_reg.running) begin
            st_next.cnt = st_reg.cnt + LEN_W'(1);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
endmodule

`default_nettype wire

// ---- design/sar_adc_parallel_control.sv ----
// Control and readout of a 12-bit successive-approximation converter.
// Assumes pins arrive synchronous to i_clk_sys, except powerdown_reset_n,
// which is synchronised here. AHB-Lite slave, single master, zero wait.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`default_nettype none
`include "sar_adc_map.svh"

module sar_adc_parallel_control #(
    parameter int RESET_PHASE_CYC = `RESET_PHASE_CYC_DEF,
    parameter int POWERDOWN_CYC = `POWERDOWN_CYC_DEF
) (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_conversion_start_n,
    input wire logic i_rd_n,
    input wire logic i_byte_sel,
    input wire logic i_nap_enable_n,
    input wire logic i_powerdown_reset_n,
    input wire logic [11:0] i_sar_code,
    output logic o_busy,
    output logic o_sampling,
    output logic o_nap,
    output logic o_reset_phase,
    output logic o_powerdown,
    output logic o_result_valid,
    output logic [11:0] o_result_bus,
    output logic o_result_bus_oe,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata
);
    localparam sar_adc_pkg::ctl_state_s ST_RESET = '{
        state: sar_adc_pkg::ST_IDLE,
        cs_prev: 1'b1,
        cst_prev: 1'b1,
        pwd_meta: 1'b1,
        pwd_sync: 1'b1,
        conv_len: `LEN_W'(`CONV_CYC),
        default: '0
    };

    sar_adc_pkg::ctl_state_s st_reg;
    sar_adc_pkg::ctl_state_s st_next;

    logic cs_fall;
    logic cst_rise;
    logic cst_fall;
    logic busy;
    logic pwd_low;
    logic samp_evt;
    logic conv_evt;
    logic abort_evt;
    logic addr_phase;
    logic conv_done;
    logic timer_start;
    logic timer_stop;

    // Register read view; used by the address phase of every read
    function automatic logic [31:0] reg_read(input logic [7:0] a,
                                             input sar_adc_pkg::ctl_state_s s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (a)
            `REG_CTRL: v[`LEN_W-1:0] = s.conv_len;
            `REG_STATUS: begin
                v[`STAT_BUSY] = s.state != sar_adc_pkg::ST_IDLE;
                v[`STAT_SAMPLING] = s.sampling;
                v[`STAT_NAP] = s.nap;
                v[`STAT_RESET] = s.reset_phase;
                v[`STAT_PWRDN] = s.powerdown;
                v[`STAT_ABORTED] = s.aborted;
                v[`STAT_VALID] = s.init_cnt == `INIT_CONVS;
                v[`STAT_INIT_LSB +: 3] = s.init_cnt;
            end
            `REG_RESULT: v[11:0] = s.result;
            `REG_COUNT: v[15:0] = s.conv_total;
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Edges are taken against the previous cycle's pin levels
    assign cs_fall = st_reg.cs_prev && !i_cs_n;
    assign cst_rise = !st_reg.cst_prev && i_conversion_start_n;
    assign cst_fall = st_reg.cst_prev && !i_conversion_start_n;
    assign busy = st_reg.state != sar_adc_pkg::ST_IDLE;
    assign pwd_low = !st_reg.pwd_sync;
    assign samp_evt = !busy && ((cst_rise && !i_cs_n) ||
                                (cs_fall && i_conversion_start_n));
    assign conv_evt = (st_reg.state != sar_adc_pkg::ST_CONVERT) &&
                      (cst_fall || (cs_fall && !i_conversion_start_n));
    assign abort_evt = (st_reg.state == sar_adc_pkg::ST_CONVERT) && cs_fall &&
                       i_conversion_start_n;
    assign addr_phase = i_hsel && i_htrans[1] && i_hready;
    assign timer_start = conv_evt && !pwd_low;
    assign timer_stop = abort_evt || pwd_low;

    sar_conv_timer #(
        .LEN_W(`LEN_W)
    ) u_timer (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .i_start(timer_start),
        .i_stop(timer_stop),
        .i_length(st_reg.conv_len),
        .o_running(),
        .o_done(conv_done)
    );

    always_comb begin
        st_next = st_reg;
        st_next.cs_prev = i_cs_n;
        st_next.cst_prev = i_conversion_start_n;
        // Two-stage synchroniser; only the second stage is looked at
        st_next.pwd_meta = i_powerdown_reset_n;
        st_next.pwd_sync = st_reg.pwd_meta;

        if (pwd_low) begin
            if (st_reg.pwd_cnt != 16'hFFFF) begin
                st_next.pwd_cnt = st_reg.pwd_cnt + 16'h0001;
            end
        end else begin
            st_next.pwd_cnt = 16'h0000;
        end
        st_next.reset_phase = pwd_low && (st_reg.pwd_cnt < 16'(RESET_PHASE_CYC));
        st_next.powerdown = pwd_low && (st_reg.pwd_cnt >= 16'(POWERDOWN_CYC));

        if (pwd_low) begin
            // Rising input releases all of this at once: no wake-up delay
            st_next.state = sar_adc_pkg::ST_IDLE;
            st_next.sampling = 1'b0;
            st_next.init_cnt = 3'h0;
            if (st_reg.pwd_cnt < 16'(RESET_PHASE_CYC)) begin
                st_next.result = `ABORT_CODE;
            end
        end else begin
            unique case (st_reg.state)
                sar_adc_pkg::ST_IDLE: begin
                    if (conv_evt) begin
                        st_next.state = sar_adc_pkg::ST_CONVERT;
                        st_next.sampling = 1'b0;
                    end else if (samp_evt) begin
                        st_next.sampling = 1'b1;
                    end
                end
                sar_adc_pkg::ST_CONVERT: begin
                    if (abort_evt) begin
                        st_next.state = sar_adc_pkg::ST_IDLE;
                        st_next.result = `ABORT_CODE;
                        st_next.aborted = 1'b1;
                    end else if (conv_done) begin
                        // Straight binary code from the comparator array
                        st_next.state = sar_adc_pkg::ST_TAIL;
                        st_next.result = i_sar_code;
                        st_next.aborted = 1'b0;
                        st_next.conv_total = st_reg.conv_total + 16'h0001;
                        if (st_reg.init_cnt != `INIT_CONVS) begin
                            st_next.init_cnt = st_reg.init_cnt + 3'h1;
                        end
                        if (!i_cs_n && i_conversion_start_n) begin
                            st_next.sampling = 1'b1;
                        end
                    end
                end
                sar_adc_pkg::ST_TAIL: begin
                    // Busy lags the internal end by one cycle
                    if (conv_evt) begin
                        st_next.state = sar_adc_pkg::ST_CONVERT;
                        st_next.sampling = 1'b0;
                    end else begin
                        st_next.state = sar_adc_pkg::ST_IDLE;
                    end
                end
                default: st_next.state = sar_adc_pkg::ST_IDLE;
            endcase
        end

        st_next.nap = !i_nap_enable_n && !pwd_low && !st_next.sampling &&
                      (st_next.state == sar_adc_pkg::ST_IDLE);

        // Output word is registered, so a byte switch shows one cycle later
        if (i_byte_sel) begin
            st_next.bus_data = {st_reg.result[3:0], 8'h00};
        end else begin
            st_next.bus_data = st_reg.result;
        end

        st_next.wr_pend = addr_phase && i_hwrite;
        if (addr_phase) begin
            st_next.wr_addr = i_haddr[7:0];
        end
        if (addr_phase && !i_hwrite) begin
            st_next.hrdata = reg_read(i_haddr[7:0], st_reg);
        end
        if (st_reg.wr_pend && st_reg.wr_addr == `REG_CTRL) begin
            // Zero length is taken as one; the timer ends after one count for either
            if (i_hwdata[`LEN_W-1:0] == `LEN_W'(0)) begin
                st_next.conv_len = `LEN_W'(1);
            end else begin
                st_next.conv_len = i_hwdata[`LEN_W-1:0];
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_busy = busy;
    assign o_sampling = st_reg.sampling;
    assign o_nap = st_reg.nap;
    assign o_reset_phase = st_reg.reset_phase;
    assign o_powerdown = st_reg.powerdown;
    assign o_result_valid = st_reg.init_cnt == `INIT_CONVS;
    assign o_result_bus = st_reg.bus_data;
    assign o_result_bus_oe = !i_cs_n && !i_rd_n;
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = st_reg.hrdata;

    a_busy_start:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        timer_start |=> o_busy ##1 o_busy)
        else $error("busy did not rise after conversion start");

    a_busy_hold:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ($rose(o_busy) && st_reg.conv_len >= `LEN_W'(8) && !pwd_low &&
         i_conversion_start_n == 1'b0 && i_cs_n == 1'b0 && i_powerdown_reset_n)
        |-> o_busy[*3])
        else $error("busy dropped early without abort or reset");

    a_busy_fall:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (conv_done && !abort_evt && !pwd_low && !conv_evt) |=> o_busy ##1
        (!o_busy || $past(conv_evt)))
        else $error("busy did not fall one cycle after conversion end");

    a_abort_code:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (abort_evt && !pwd_low) |=> (!o_busy && st_reg.result == `ABORT_CODE
                                     && st_reg.aborted))
        else $error("abort did not end busy with code FE0");

    a_back_sample:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_reg.state == sar_adc_pkg::ST_CONVERT && conv_done && !abort_evt &&
         !pwd_low && !i_cs_n && i_conversion_start_n) |=> (o_sampling && o_busy))
        else $error("sampling did not start at internal conversion end");

    a_fold_read:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        i_byte_sel |=> o_result_bus == {$past(st_reg.result[3:0]), 8'h00})
        else $error("byte mode word not folded");

    a_full_read:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        !i_byte_sel |=> o_result_bus == $past(st_reg.result))
        else $error("full word read mismatch");

    a_bus_release:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_cs_n || i_rd_n) |-> !o_result_bus_oe)
        else $error("bus driven while cs or read high");

    a_reset_code:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(st_reg.reset_phase) |-> st_reg.result == `ABORT_CODE)
        else $error("reset phase without code FE0");

    a_reset_abort:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_powerdown_reset_n [*4]) |-> !o_busy)
        else $error("conversion not aborted by reset in time");

    a_powerdown_entry:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        $rose(o_powerdown) |-> (pwd_low && !o_busy && !o_reset_phase))
        else $error("powerdown entered without long low input");

    a_nap_hold:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        o_nap |-> (!o_busy && !o_sampling && !$past(i_nap_enable_n)))
        else $error("nap while busy, sampling or disabled");

    a_nap_after_busy:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ($fell(o_busy) && !o_sampling && !pwd_low && !$past(i_nap_enable_n)
         && !i_nap_enable_n) |=> o_nap || o_sampling || o_busy || pwd_low)
        else $error("nap not entered after busy fell");

    a_bus_drive:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!i_cs_n && !i_rd_n) |-> o_result_bus_oe)
        else $error("bus not driven while cs and read low");

    a_sample_start:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (samp_evt && !conv_evt && !pwd_low) |=> o_sampling)
        else $error("sampling did not start on a start edge");

    a_init_done:
    assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (st_reg.state == sar_adc_pkg::ST_CONVERT && conv_done && !abort_evt && !pwd_low &&
         st_reg.init_cnt == `INIT_CONVS - 3'h1) |=> o_result_valid)
        else $error("result not valid after fourth conversion");
endmodule

`default_nettype wire

// ---- testbench/host_model.sv ----
// Host controller model driving the converter's chip select and strobes.
// Assumes a free-running i_clk_sys; the bench calls its tasks in order.
`default_nettype none

module host_model (
    input wire logic i_clk_sys,
    output logic o_cs_n,
    output logic o_conversion_start_n,
    output logic o_rd_n,
    output logic o_byte_sel,
    output logic o_rd_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        o_cs_n = 1'b1;
        o_conversion_start_n = 1'b1;
        o_rd_n = 1'b1;
        o_byte_sel = 1'b0;
        o_rd_strobe = 1'b0;
    end

    // A long n gives the longer acquisition needed after nap
    task automatic pins(input logic c, input logic s, input int n);
        @(posedge i_clk_sys);
        o_cs_n <= c;
        o_conversion_start_n <= s;
        repeat (n) @(posedge i_clk_sys);
    endtask

    // Reads only while idle, never near a start edge
    task automatic rd_bus(input logic b);
        @(posedge i_clk_sys);
        o_cs_n <= 1'b0;
        o_rd_n <= 1'b0;
        o_byte_sel <= b;
        repeat (2) @(posedge i_clk_sys);
        o_rd_strobe <= 1'b1;
        @(posedge i_clk_sys);
        o_rd_strobe <= 1'b0;
        o_rd_n <= 1'b1;
    endtask
endmodule

`default_nettype wire

// ---- testbench/sar_adc_parallel_control_bench.sv ----
// Bench for the converter control block: pin traffic and register reads.
// Assumes host_model and the design files are compiled first.
`default_nettype none

module sar_adc_parallel_control_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int LEN = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic nap_n = 1'b1;
    logic pwd_n = 1'b1;
    logic [11:0] sar_code = 12'h000;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    wire logic cs_n, cst_n, rd_n, byte_sel, rd_strobe;
    wire logic busy, samp, nap, rphase, pdown, valid, oe, hready, hresp;
    wire logic [11:0] bus;
    wire logic [31:0] hrdata;
    logic [11:0] exp_bus[$];
    logic [31:0] exp_reg[$];
    logic dp_rd = 1'b0;
    logic seen;
    int err_count = 0;
    int check_count = 0;
    int unsigned seed_v;
    logic [11:0] c;

    always #2.5 clk = ~clk;

    host_model u_host_model (.i_clk_sys(clk), .o_cs_n(cs_n), .o_conversion_start_n(cst_n),
        .o_rd_n(rd_n), .o_byte_sel(byte_sel), .o_rd_strobe(rd_strobe));

    sar_adc_parallel_control #(.RESET_PHASE_CYC(16), .POWERDOWN_CYC(40))
        u_sar_adc_parallel_control (
        .i_clk_sys(clk), .i_rst(rst), .i_cs_n(cs_n), .i_conversion_start_n(cst_n),
        .i_rd_n(rd_n), .i_byte_sel(byte_sel), .i_nap_enable_n(nap_n),
        .i_powerdown_reset_n(pwd_n), .i_sar_code(sar_code), .o_busy(busy),
        .o_sampling(samp), .o_nap(nap), .o_reset_phase(rphase), .o_powerdown(pdown),
        .o_result_valid(valid), .o_result_bus(bus), .o_result_bus_oe(oe), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata));

    task automatic fail(input logic [31:0] e, input logic [31:0] g);
        err_count++;
        $display("[FAIL] %0t exp %h got %h", $time, e, g);
    endtask

    task automatic cmp_bus(input logic [12:0] e, input logic [12:0] g);
        check_count++;
        if (g !== e) fail({19'h0, e}, {19'h0, g});
    endtask

    task automatic cmp_reg(input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) fail(e, g);
    endtask

    task automatic chk(input logic g, input logic e);
        check_count++;
        if (g !== e) fail({31'h0, e}, {31'h0, g});
    endtask

    // Result watcher: pin reads and register data phases
    always @(posedge clk) begin
        if (rd_strobe === 1'b1 && exp_bus.size() > 0)
            cmp_bus({1'b1, exp_bus.pop_front()}, {oe, bus});
        if (dp_rd && hready === 1'b1 && exp_reg.size() > 0) begin
            cmp_reg(exp_reg.pop_front(), hrdata);
            chk(hresp, 1'b0);
        end
        if (hready === 1'b1) dp_rd <= hsel && htrans[1] && !hwrite;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        // Size only counts in the address phase, so it wanders here
        hsize <= 3'($urandom_range(2));
        do @(posedge clk); while (hready !== 1'b1);
    endtask

    task automatic reg_rd(input logic [31:0] a, input logic [31:0] e);
        exp_reg.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask

    task automatic read_both(input logic [11:0] v);
        exp_bus.push_back(v);
        u_host_model.rd_bus(1'b0);
        exp_bus.push_back({v[3:0], 8'h00});
        u_host_model.rd_bus(1'b1);
        step(1);
        chk(oe, 1'b0);
    endtask

    task automatic conv(input logic [11:0] v, input int acq);
        int n;
        u_host_model.pins(1'b1, 1'b1, 1);
        sar_code <= v;
        u_host_model.pins(1'b0, 1'b1, acq);
        u_host_model.pins(1'b0, 1'b0, 1);
        step(1);
        chk(busy, 1'b1);
        n = 1;
        while (busy === 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        chk(n >= LEN + 1 && n <= LEN + 2, 1'b1);
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        wrap_up();
    end

    initial begin
        seed_v = $urandom(18);
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        reg_rd(32'h00, 32'h28);
        reg_rd(32'h10, 32'h0);
        ahb(1'b1, 32'h00, 32'h0);
        reg_rd(32'h00, 32'h1);
        ahb(1'b1, 32'h00, LEN);
        reg_rd(32'h00, LEN);
        // Boundary codes first, then random ones
        for (int i = 0; i < 4; i++) begin
            c = (i == 0) ? 12'h000 : (i == 1) ? 12'hFFF : 12'($urandom());
            step(1);
            chk(valid, 1'b0);
            conv(c, 2);
            read_both(c);
        end
        chk(valid, 1'b1);
        reg_rd(32'h08, {20'h0, c});
        reg_rd(32'h0C, 32'h4);
        // Back-to-back: conversion_start_n back high mid-conversion, sampling before busy falls
        seen = 1'b0;
        u_host_model.pins(1'b0, 1'b1, 2);
        u_host_model.pins(1'b0, 1'b0, 2);
        u_host_model.pins(1'b0, 1'b1, 1);
        for (int i = 0; i < 300 && busy === 1'b1; i++) begin
            step(1);
            if (busy === 1'b1 && samp === 1'b1) seen = 1'b1;
        end
        chk(seen, 1'b1);
        // Abort by a chip select fall while converting
        u_host_model.pins(1'b0, 1'b0, 2);
        u_host_model.pins(1'b0, 1'b1, 1);
        u_host_model.pins(1'b1, 1'b1, 1);
        u_host_model.pins(1'b0, 1'b1, 1);
        step(1);
        chk(busy, 1'b0);
        read_both(12'hFE0);
        // Nap after busy falls, left at the next sampling start
        @(posedge clk) nap_n <= 1'b0;
        conv(12'($urandom()), 14);
        step(3);
        chk(nap, 1'b1);
        step(5);
        chk(nap, 1'b1);
        u_host_model.pins(1'b1, 1'b1, 1);
        u_host_model.pins(1'b0, 1'b1, 1);
        step(1);
        chk(nap, 1'b0);
        conv(12'h5A3, 14);
        @(posedge clk) nap_n <= 1'b1;
        // Powerdown input falls in mid-conversion
        u_host_model.pins(1'b0, 1'b1, 2);
        u_host_model.pins(1'b0, 1'b0, 2);
        pwd_n <= 1'b0;
        step(3);
        chk(busy, 1'b0);
        chk(rphase, 1'b1);
        exp_bus.push_back(12'hFE0);
        u_host_model.rd_bus(1'b0);
        for (int i = 0; i < 60 && pdown !== 1'b1; i++) step(1);
        chk(pdown, 1'b1);
        @(posedge clk) pwd_n <= 1'b1;
        step(4);
        chk(pdown, 1'b0);
        chk(rphase, 1'b0);
        chk(valid, 1'b0);
        conv(12'h3C6, 2);
        read_both(12'h3C6);
        step(2);
        wrap_up();
    end
endmodule

`default_nettype wire
